//--- core/status_event_regs.svh
`ifndef STATUS_EVENT_REGS_SVH
`define STATUS_EVENT_REGS_SVH

// Standard event bit positions
`define SE_BIT_OPC        0
`define SE_BIT_QUERY      2
`define SE_BIT_DEVICE     3
`define SE_BIT_EXEC       4
`define SE_BIT_CMD        5
`define SE_BIT_PWRON      7
`define SE_USED_MASK      8'hBD
`define SE_MASK_RESET     8'h00

// Doubtful-state bit positions
`define DQ_BIT_POWER      3
`define DQ_BIT_FREQ       5
`define DQ_BIT_LIMIT      9
`define DQ_USED_MASK      16'h0228

// Reference frequency bit
`define RF_BIT_EXTREF     8
`define RF_USED_MASK      16'h0100

// Activity register carries nothing
`define ACT_USED_MASK     16'h0000

// Status byte summary positions
`define STB_BIT_DOUBTFUL  3
`define STB_BIT_SUMMARY   5

// Error code ranges
`define ERR_CMD_CODE      16'hFF9C
`define ERR_EXEC_CODE     16'hFF38
`define ERR_DEV_CODE      16'hFED4

`endif

//--- core/status_event_pkg.sv
package status_event_pkg;

  typedef enum logic [2:0] {
    SEL_SE_LATCH,
    SEL_SE_MASK,
    SEL_ACT_COND,
    SEL_ACT_EVENT,
    SEL_DQ_COND,
    SEL_DQ_EVENT,
    SEL_RF_COND,
    SEL_RF_EVENT
  } query_sel_e;

  typedef logic [15:0] status_word_t;

endpackage : status_event_pkg

//--- core/status_group_if.sv
`timescale 1ns/1ps
`default_nettype none

interface status_group_if #(parameter int WIDTH = 16);
  logic [WIDTH-1:0] condition;
  logic [WIDTH-1:0] eventBits;
  logic [WIDTH-1:0] enableBits;
  logic readClear;
  logic summary;

  modport owner (
    input condition, enableBits, readClear,
    output eventBits, summary
  );
  modport user (
    output condition, enableBits, readClear,
    input eventBits, summary
  );
endinterface : status_group_if

`default_nettype wire

//--- core/status_group.sv
`timescale 1ns/1ps
`default_nettype none

module status_group #(
  parameter int WIDTH = 16,
  parameter logic [15:0] USED = 16'h0000
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Group
  status_group_if.owner grp
);

  logic [WIDTH-1:0] eventReg;
  logic [WIDTH-1:0] eventNext;
  logic [WIDTH-1:0] riseMask;
  logic [WIDTH-1:0] condPrevReg;

  // Rising condition latches; set beats the read clear
  assign riseMask = grp.condition & ~condPrevReg & USED[WIDTH-1:0]; // R18
  assign eventNext = (grp.readClear ? '0 : eventReg) | riseMask; // R17

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      eventReg <= '0;
      condPrevReg <= '0;
    end else begin
      eventReg <= eventNext;
      condPrevReg <= grp.condition;
    end
  end

  assign grp.eventBits = eventReg;
  assign grp.summary = |(eventReg & grp.enableBits); // R16

  event_hold_a: assert property ( // R17
    @(posedge sys_clk) disable iff (!reset_n) !grp.readClear |=>
      (eventReg & $past(eventReg)) == $past(eventReg))
    else $error("Event bit lost without read");
  unused_zero_a: assert property ( // R18
    @(posedge sys_clk) disable iff (!reset_n)
    (eventReg & ~USED[WIDTH-1:0]) == '0)
    else $error("Unused event bit set");

endmodule : status_group

`default_nettype wire

//--- core/instrument_status_event_registers.sv
`timescale 1ns/1ps
`default_nettype none
`include "status_event_regs.svh"

// Operation
// [R1] Operation complete sets bit 0 after drain
// [R2] Query protocol errors set bit 2
// [R3] Device fault sets bit 3, queues code
// [R4] Execution failure sets bit 4, queues code
// [R5] Bad command sets bit 5, queues code
// [R6] Power on sets bit 7
// [R7] Latch queryable, mask written and read
// [R8] Activity register condition and event parts
// [R9] Bit 15 zero; activity carries nothing
// [R10] Questionable bit 3 on doubtful power
// [R11] Questionable bit 5 on frequency fault
// [R12] Questionable bit 9 on limit violation
// [R13] Reference bit 8 while external reference
// [R14] Questionable condition and event separately readable
// [R15] Status bit 5 from enabled event
// [R16] Status bit 3 from enabled questionable
// [R17] Events latch until their query reads
// [R18] Unused bits zero, no summary
module instrument_status_event_registers #(
  parameter int SE_WIDTH = 8,
  parameter int ST_WIDTH = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Command events
  input wire logic opcCommand,
  input wire logic commandsPending,
  input wire logic readWithoutQuery,
  input wire logic responseAbandoned,
  input wire logic deviceFault,
  input wire logic executionFault,
  input wire logic commandFault,
  // Instrument conditions
  input wire logic powerDoubtful,
  input wire logic freqFault,
  input wire logic limitViolated,
  input wire logic externalRefUsed,
  // Mask and enable writes
  input wire logic maskWrite,
  input wire logic [SE_WIDTH-1:0] maskData,
  input wire logic [ST_WIDTH-1:0] doubtfulEnable,
  // Query port
  input wire logic queryStrobe,
  input wire logic [2:0] querySelect,
  output logic [ST_WIDTH-1:0] queryData,
  output logic queryValid,
  // Error queue push
  output logic errorPush,
  output logic [15:0] errorCode,
  // Summaries
  output logic [7:0] statusSummary
);

  logic [SE_WIDTH-1:0] seLatchReg;
  logic [SE_WIDTH-1:0] seLatchNext;
  logic [SE_WIDTH-1:0] seSet;
  logic [SE_WIDTH-1:0] seMaskReg;
  logic opcArmedReg;
  logic opcFire;
  logic powerOnReg;
  logic seSummary;
  logic [ST_WIDTH-1:0] queryDataReg;
  logic queryValidReg;
  logic errorPushReg;
  logic [15:0] errorCodeReg;
  logic [ST_WIDTH-1:0] dqCond;
  logic [ST_WIDTH-1:0] rfCond;
  logic [ST_WIDTH-1:0] actCond;
  logic [ST_WIDTH-1:0] queryMux;
  logic rdSeLatch;

  status_group_if #(.WIDTH(ST_WIDTH)) actGrp ();
  status_group_if #(.WIDTH(ST_WIDTH)) dqGrp ();
  status_group_if #(.WIDTH(ST_WIDTH)) rfGrp ();

  // Strobe passed in so continuous decodes follow it
  function automatic logic sel_is(input logic strobe, input logic [2:0] s,
                                  input status_event_pkg::query_sel_e v);
    sel_is = strobe && (s == 3'(v));
  endfunction : sel_is

  // Operation complete waits for earlier commands to drain
  assign opcFire = (opcCommand || opcArmedReg) && !commandsPending; // R1

  assign seSet = SE_WIDTH'(
      ({7'h00, opcFire} << `SE_BIT_OPC) | // R1
      ({7'h00, readWithoutQuery | responseAbandoned} << `SE_BIT_QUERY) | // R2
      ({7'h00, deviceFault} << `SE_BIT_DEVICE) | // R3
      ({7'h00, executionFault} << `SE_BIT_EXEC) | // R4
      ({7'h00, commandFault} << `SE_BIT_CMD) | // R5
      ({7'h00, powerOnReg} << `SE_BIT_PWRON)); // R6

  assign rdSeLatch = sel_is(queryStrobe, querySelect,
      status_event_pkg::SEL_SE_LATCH);
  // Set wins over the read clear
  assign seLatchNext = ((rdSeLatch ? '0 : seLatchReg) | seSet)
      & `SE_USED_MASK; // R17
  assign seSummary = |(seLatchReg & seMaskReg); // R15

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      seLatchReg <= '0;
      opcArmedReg <= 1'b0;
      powerOnReg <= 1'b1;
    end else begin
      seLatchReg <= seLatchNext; // R7
      opcArmedReg <= (opcCommand || opcArmedReg) && commandsPending; // R1
      powerOnReg <= 1'b0; // R6
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      seMaskReg <= `SE_MASK_RESET;
    end else if (maskWrite) begin
      seMaskReg <= maskData; // R7
    end
  end

  // Error code with highest severity when several arrive together
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      errorPushReg <= 1'b0;
      errorCodeReg <= 16'h0000;
    end else begin
      errorPushReg <= deviceFault | executionFault | commandFault;
      if (deviceFault) begin
        errorCodeReg <= `ERR_DEV_CODE; // R3
      end else if (executionFault) begin
        errorCodeReg <= `ERR_EXEC_CODE; // R4
      end else if (commandFault) begin
        errorCodeReg <= `ERR_CMD_CODE; // R5
      end
    end
  end

  // Condition parts; bit 15 is never driven
  assign actCond = `ACT_USED_MASK; // R9
  assign dqCond = ST_WIDTH'(
      ({15'h0000, powerDoubtful} << `DQ_BIT_POWER) | // R10
      ({15'h0000, freqFault} << `DQ_BIT_FREQ) | // R11
      ({15'h0000, limitViolated} << `DQ_BIT_LIMIT)); // R12
  assign rfCond = ST_WIDTH'({15'h0000, externalRefUsed} << `RF_BIT_EXTREF); // R13

  assign actGrp.condition = actCond; // R8
  assign actGrp.enableBits = '0;
  assign actGrp.readClear = sel_is(queryStrobe, querySelect,
      status_event_pkg::SEL_ACT_EVENT);
  assign dqGrp.condition = dqCond; // R14
  assign dqGrp.enableBits = doubtfulEnable & `DQ_USED_MASK;
  assign dqGrp.readClear = sel_is(queryStrobe, querySelect,
      status_event_pkg::SEL_DQ_EVENT);
  assign rfGrp.condition = rfCond;
  assign rfGrp.enableBits = '0;
  assign rfGrp.readClear = sel_is(queryStrobe, querySelect,
      status_event_pkg::SEL_RF_EVENT);

  status_group #(.WIDTH(ST_WIDTH), .USED(`ACT_USED_MASK)) u_act (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .grp(actGrp.owner)
  );
  status_group #(.WIDTH(ST_WIDTH), .USED(`DQ_USED_MASK)) u_dq (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .grp(dqGrp.owner)
  );
  status_group #(.WIDTH(ST_WIDTH), .USED(`RF_USED_MASK)) u_rf (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .grp(rfGrp.owner)
  );

  always_comb begin
    case (querySelect)
      3'(status_event_pkg::SEL_SE_LATCH): queryMux = ST_WIDTH'(seLatchReg);
      3'(status_event_pkg::SEL_SE_MASK): queryMux = ST_WIDTH'(seMaskReg);
      3'(status_event_pkg::SEL_ACT_COND): queryMux = actCond;
      3'(status_event_pkg::SEL_ACT_EVENT): queryMux = actGrp.eventBits;
      3'(status_event_pkg::SEL_DQ_COND): queryMux = dqCond;
      3'(status_event_pkg::SEL_DQ_EVENT): queryMux = dqGrp.eventBits;
      3'(status_event_pkg::SEL_RF_COND): queryMux = rfCond;
      3'(status_event_pkg::SEL_RF_EVENT): queryMux = rfGrp.eventBits;
      default: queryMux = '0;
    endcase
  end

  // Answer registered one cycle after the strobe
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      queryDataReg <= '0;
      queryValidReg <= 1'b0;
    end else begin
      queryValidReg <= queryStrobe;
      if (queryStrobe) begin
        queryDataReg <= queryMux & 16'h7FFF; // R9
      end
    end
  end

  assign queryData = queryDataReg;
  assign queryValid = queryValidReg;
  assign errorPush = errorPushReg;
  assign errorCode = errorCodeReg;
  assign statusSummary = {2'b00, seSummary, 1'b0, dqGrp.summary, 3'b000}; // R15

  // Command events
  opc_wait_a: assert property ( // R1
    @(posedge sys_clk) disable iff (!reset_n)
    (commandsPending && !seLatchReg[`SE_BIT_OPC])
      |=> !seLatchReg[`SE_BIT_OPC])
    else $error("Operation complete before drain");
  opc_drain_a: assert property ( // R1
    @(posedge sys_clk) disable iff (!reset_n)
    (opcArmedReg && !commandsPending) |=> seLatchReg[`SE_BIT_OPC])
    else $error("Operation complete missing after drain");
  query_err_a: assert property ( // R2
    @(posedge sys_clk) disable iff (!reset_n)
    (readWithoutQuery || responseAbandoned) |=> seLatchReg[`SE_BIT_QUERY])
    else $error("Query error not latched");
  dev_err_a: assert property ( // R3
    @(posedge sys_clk) disable iff (!reset_n)
    deviceFault |=> seLatchReg[`SE_BIT_DEVICE] && errorPush
      && errorCode == `ERR_DEV_CODE)
    else $error("Device fault not reported");
  err_quiet_a: assert property ( // R3
    @(posedge sys_clk) disable iff (!reset_n)
    !(deviceFault || executionFault || commandFault) |=> !errorPush)
    else $error("Error pushed without fault");
  exec_err_a: assert property ( // R4
    @(posedge sys_clk) disable iff (!reset_n)
    (executionFault && !deviceFault) |=> seLatchReg[`SE_BIT_EXEC]
      && errorCode == `ERR_EXEC_CODE)
    else $error("Execution fault not reported");
  cmd_err_a: assert property ( // R5
    @(posedge sys_clk) disable iff (!reset_n)
    (commandFault && !deviceFault && !executionFault)
      |=> seLatchReg[`SE_BIT_CMD] && errorCode == `ERR_CMD_CODE)
    else $error("Command fault not reported");
  power_on_a: assert property ( // R6
    @(posedge sys_clk) disable iff (!reset_n)
    powerOnReg |=> seLatchReg[`SE_BIT_PWRON])
    else $error("Power on bit not latched");

  // Mask and latch
  mask_write_a: assert property ( // R7
    @(posedge sys_clk) disable iff (!reset_n)
    maskWrite |=> seMaskReg == $past(maskData))
    else $error("Mask write lost");
  mask_hold_a: assert property ( // R7
    @(posedge sys_clk) disable iff (!reset_n)
    !maskWrite |=> $stable(seMaskReg))
    else $error("Mask changed without write");
  latch_hold_a: assert property ( // R17
    @(posedge sys_clk) disable iff (!reset_n)
    !rdSeLatch |=> (seLatchReg & $past(seLatchReg)) == $past(seLatchReg))
    else $error("Event cleared without read");
  rd_clear_a: assert property ( // R17
    @(posedge sys_clk) disable iff (!reset_n)
    (rdSeLatch && seSet == '0) |=> seLatchReg == '0)
    else $error("Event latch not cleared by read");

  // Status groups
  act_zero_a: assert property ( // R9
    @(posedge sys_clk) disable iff (!reset_n)
    actGrp.eventBits == '0)
    else $error("Activity event bit set");
  bit15_zero_a: assert property ( // R9
    @(posedge sys_clk) disable iff (!reset_n)
    queryValid |-> !queryData[15])
    else $error("Bit 15 read as one");
  dq_power_a: assert property ( // R10
    @(posedge sys_clk) disable iff (!reset_n)
    $rose(powerDoubtful) |=> dqGrp.eventBits[`DQ_BIT_POWER])
    else $error("Power event not latched");
  dq_freq_a: assert property ( // R11
    @(posedge sys_clk) disable iff (!reset_n)
    $rose(freqFault) |=> dqGrp.eventBits[`DQ_BIT_FREQ])
    else $error("Frequency event not latched");
  dq_limit_a: assert property ( // R12
    @(posedge sys_clk) disable iff (!reset_n)
    $rose(limitViolated) |=> dqGrp.eventBits[`DQ_BIT_LIMIT])
    else $error("Limit event not latched");
  ref_ext_a: assert property ( // R13
    @(posedge sys_clk) disable iff (!reset_n)
    $rose(externalRefUsed) |=> rfGrp.eventBits[`RF_BIT_EXTREF])
    else $error("Reference event not latched");

  // Summaries
  se_summary_a: assert property ( // R15
    @(posedge sys_clk) disable iff (!reset_n)
    statusSummary[`STB_BIT_SUMMARY] == |(seLatchReg & seMaskReg))
    else $error("Event summary mismatch");
  dq_summary_a: assert property ( // R16
    @(posedge sys_clk) disable iff (!reset_n)
    statusSummary[`STB_BIT_DOUBTFUL]
      == |(dqGrp.eventBits & doubtfulEnable & `DQ_USED_MASK))
    else $error("Questionable summary mismatch");
  summary_zero_a: assert property ( // R18
    @(posedge sys_clk) disable iff (!reset_n)
    (statusSummary & 8'hD7) == 8'h00)
    else $error("Unused summary bit set");

  // Query handshake
  query_valid_a: assert property ( // R7
    @(posedge sys_clk) disable iff (!reset_n)
    queryStrobe |=> queryValid)
    else $error("Query answer missing");

  opc_cov: cover property (@(posedge sys_clk) disable iff (!reset_n)
    opcCommand && commandsPending ##[1:20] seLatchReg[`SE_BIT_OPC]);
  srq_cov: cover property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(statusSummary[`STB_BIT_SUMMARY]));
  dq_cov: cover property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(statusSummary[`STB_BIT_DOUBTFUL]));
  err_cov: cover property (@(posedge sys_clk) disable iff (!reset_n)
    deviceFault && executionFault && commandFault);
  ref_cov: cover property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(rfGrp.eventBits[`RF_BIT_EXTREF]));

endmodule : instrument_status_event_registers

`default_nettype wire

//--- test/status_controller_model.sv
`timescale 1ns/1ps
`default_nettype none

module status_controller_model (
  // Clock
  input wire logic sys_clk,
  // Query port
  output logic queryStrobe,
  output logic [2:0] querySelect,
  input wire logic [15:0] queryData,
  input wire logic queryValid,
  // Mask write
  output logic maskWrite,
  output logic [7:0] maskData
);
  initial begin
    queryStrobe = 1'b0;
    querySelect = 3'h0;
    maskWrite = 1'b0;
    maskData = 8'h00;
  end

  // Select is scrambled once taken, so a design that samples late sees junk
  task automatic query(input logic [2:0] sel, output logic [15:0] data);
    int n;
    n = 0;
    @(negedge sys_clk);
    queryStrobe = 1'b1;
    querySelect = sel;
    @(negedge sys_clk);
    queryStrobe = 1'b0;
    querySelect = ~sel;
    while (queryValid !== 1'b1 && n < 8) begin
      @(negedge sys_clk);
      n++;
    end
    data = (queryValid === 1'b1) ? queryData : 16'hXXXX;
  endtask : query

  task automatic writeMask(input logic [7:0] data);
    @(negedge sys_clk);
    maskWrite = 1'b1;
    maskData = data;
    @(negedge sys_clk);
    maskWrite = 1'b0;
    maskData = ~data;
  endtask : writeMask
endmodule : status_controller_model

`default_nettype wire

//--- test/test_instrument_status_event_registers.sv
`timescale 1ns/1ps
`default_nettype none
`include "status_event_regs.svh"

module test_instrument_status_event_registers;
  logic sys_clk, reset_n, commandsPending, queryStrobe, queryValid;
  logic maskWrite, errorPush;
  logic [5:0] evtIn, ev;
  logic [3:0] cond, prevCond;
  logic [7:0] maskData, statusSummary, seExp, m;
  logic [2:0] querySelect;
  logic [15:0] queryData, errorCode, doubtfulEnable, rd, dqEvt, rfEvt;
  int failCount, totalChecks;
  logic [15:0] codes [3] = '{`ERR_DEV_CODE, `ERR_EXEC_CODE, `ERR_CMD_CODE};

  instrument_status_event_registers u_dut (.sys_clk(sys_clk),
    .reset_n(reset_n), .opcCommand(evtIn[0]),
    .commandsPending(commandsPending), .readWithoutQuery(evtIn[1]),
    .responseAbandoned(evtIn[2]), .deviceFault(evtIn[3]),
    .executionFault(evtIn[4]), .commandFault(evtIn[5]),
    .powerDoubtful(cond[0]), .freqFault(cond[1]), .limitViolated(cond[2]),
    .externalRefUsed(cond[3]), .maskWrite(maskWrite), .maskData(maskData),
    .doubtfulEnable(doubtfulEnable), .queryStrobe(queryStrobe),
    .querySelect(querySelect), .queryData(queryData),
    .queryValid(queryValid), .errorPush(errorPush), .errorCode(errorCode),
    .statusSummary(statusSummary));

  status_controller_model u_ctl (.sys_clk(sys_clk),
    .queryStrobe(queryStrobe), .querySelect(querySelect),
    .queryData(queryData), .queryValid(queryValid),
    .maskWrite(maskWrite), .maskData(maskData));

  always #2.5 sys_clk = ~sys_clk;

  function automatic logic [7:0] seBits(input logic [5:0] v);
    return {2'b00, v[5:3], v[2] | v[1], 1'b0, v[0]};
  endfunction : seBits

  function automatic logic [15:0] codeFor(input logic [5:0] v);
    return v[3] ? `ERR_DEV_CODE : (v[4] ? `ERR_EXEC_CODE : `ERR_CMD_CODE);
  endfunction : codeFor

  function automatic logic [15:0] dqWord(input logic [3:0] c);
    return {6'h00, c[2], 3'h0, c[1], 1'b0, c[0], 3'h0};
  endfunction : dqWord

  task automatic check(input logic [15:0] got, exp, input string msg);
    totalChecks++;
    if (got !== exp) begin
      failCount++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got,
        exp);
    end
  endtask : check

  task automatic pulse(input logic [5:0] v);
    @(negedge sys_clk);
    evtIn = v;
    @(negedge sys_clk);
    evtIn = 6'h00;
  endtask : pulse

  task automatic readLatch(input logic [7:0] exp);
    u_ctl.query(3'h0, rd);
    check(rd, {8'h00, exp}, "event latch");
  endtask : readLatch

  task automatic endSim;
    $display("checks %0d mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : endSim

  initial begin
    #(20000 * 5);
    failCount++;
    endSim();
  end

  initial begin
    sys_clk = 1'b0;
    reset_n = 1'b0;
    evtIn = 6'h00;
    cond = 4'h0;
    prevCond = 4'h0;
    commandsPending = 1'b0;
    doubtfulEnable = 16'h0000;
    dqEvt = 16'h0000;
    rfEvt = 16'h0000;
    failCount = 0;
    totalChecks = 0;
    rd = 16'($urandom(24));
    repeat (6) @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (3) @(negedge sys_clk);
    readLatch(8'h80);
    readLatch(8'h00);
    for (int i = 0; i < 3; i++) begin
      pulse(6'h08 << i);
      check({15'h0, errorPush}, 16'h0001, "err push");
      check(errorCode, codes[i], "err code");
    end
    readLatch(8'h38);
    pulse(6'h38);
    check(errorCode, `ERR_DEV_CODE, "error priority");
    readLatch(8'h38);
    pulse(6'h02);
    pulse(6'h04);
    readLatch(8'h04);
    commandsPending = 1'b1;
    pulse(6'h01);
    repeat (4) @(negedge sys_clk);
    readLatch(8'h00);
    commandsPending = 1'b0;
    repeat (3) @(negedge sys_clk);
    readLatch(8'h01);
    for (int i = 0; i < 10; i++) begin
      m = (i == 0) ? 8'hFF : 8'($urandom);
      u_ctl.writeMask(m);
      u_ctl.query(3'h1, rd);
      check(rd, {8'h00, m}, "mask readback");
      ev = 6'($urandom);
      seExp = seBits(ev);
      pulse(ev);
      check({15'h0, errorPush}, {15'h0, |seExp[5:3]}, "push");
      if (|ev[5:3]) check(errorCode, codeFor(ev), "code");
      repeat (2) @(negedge sys_clk);
      check({15'h0, statusSummary[5]}, {15'h0, |(seExp & m)}, "sum");
      check({8'h00, statusSummary & 8'hD7}, 16'h0000, "unused");
      readLatch(seExp);
    end
    for (int i = 0; i < 16; i++) begin
      cond = (i == 0) ? 4'hF : 4'($urandom);
      doubtfulEnable = 16'($urandom);
      dqEvt |= dqWord(cond & ~prevCond);
      rfEvt |= {7'h00, cond[3] & ~prevCond[3], 8'h00};
      prevCond = cond;
      repeat (3) @(negedge sys_clk);
      check({15'h0, statusSummary[3]}, {15'h0, |(dqEvt & doubtfulEnable)},
        "doubtful sum");
      u_ctl.query(3'h4, rd);
      check(rd, dqWord(cond), "doubtful cond");
      u_ctl.query(3'h5, rd);
      check(rd, dqEvt, "doubtful event");
      dqEvt = 16'h0000;
      u_ctl.query(3'h6, rd);
      check(rd, {7'h00, cond[3], 8'h00}, "ref cond");
      u_ctl.query(3'h7, rd);
      check(rd, rfEvt, "ref event");
      rfEvt = 16'h0000;
      for (int s = 2; s < 4; s++) begin
        u_ctl.query(3'(s), rd);
        check(rd, 16'h0000, "activity");
      end
    end
    endSim();
  end
endmodule : test_instrument_status_event_registers

`default_nettype wire
